// ===== rtl/iocpm_regs.vh
// Constants for the I/O channel priority and multiplexer status block
// Functional notes
// - Storage priority fixed: channels 6,1,2,5,3,4,7, then 0 last.
// - Nine interrupt levels exist; one is unused, eight serve channel sources.
// - Interrupt levels 1..8: storage facility, sel1-4, comms, mux std, table.
// - Multiplexer serves all subchannels concurrently, interleaving service.
// - Basic 8 subsystems, 15 subchannels; options give 16 and 63.
// - Standard status accepted from one subsystem at a time, one request.
// - While standard interrupt pends, further standard status is refused.
// - Hold-off asserted from pending entry until interrupt cleared.
// - After release, accept highest-priority presenter and pend again.
// - Pending means status accepted, request and hold-off both raised.
// - Program-flagged command word on standard subchannel also enters pending.
// - Non-stacking subchannel status is always taken when presented; code takes one per cycle, lowest index first, others wait.
// - Status table serves at most 29 non-stacking subchannels.
// - Status table subchannel writes accepted status to main storage.
// - Standard or non-stacking classification comes only from device address.
// - Standard address: leading 1, 4-bit subchannel, 3-bit device.
// - Comms address: 000+5 bits, or 0, don't-care, 6 bits.
// - Channel ignores the 3-bit device field of standard addresses.
// - 8-bit device address supplied per instruction, kept for the operation.
// - Storage grant lasts exactly one storage cycle, then released.
// - Each channel has its own request; winner gets a unique grant.
`ifndef IOCPM_REGS_VH
`define IOCPM_REGS_VH

// ----------------------------------------
// Wishbone register offsets (byte addresses)
// ----------------------------------------
`define IOCPM_REG_CTRL 8'h00
`define IOCPM_REG_STATUS 8'h04
`define IOCPM_REG_STD_STAT 8'h08
`define IOCPM_REG_TABLE 8'h0C
`define IOCPM_REG_GRANT 8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define IOCPM_CTRL_CLEAR 0
`define IOCPM_CTRL_WIDE 1
`define IOCPM_CTRL_DEFAULT 2'h0

// ----------------------------------------
// Status fields
// ----------------------------------------
`define IOCPM_ST_PEND 0
`define IOCPM_ST_HOLD 1
`define IOCPM_ST_PCI 2
`define IOCPM_ST_TBL 3

// ----------------------------------------
// Limits and encodings
// ----------------------------------------
`define IOCPM_MAX_COMM_SUB 6'h1D
`define IOCPM_LEVEL_NONE 4'h0
`define IOCPM_MUX_STD_LEVEL 4'h7
`define IOCPM_MUX_TBL_LEVEL 4'h8
`define IOCPM_STORE_CYCLES 4'h1

`endif

// ===== rtl/iocpm_top.v
// I/O channel storage/interrupt priority and multiplexer status acceptance
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "iocpm_regs.vh"

module iocpm_top #(
    parameter N_SUBSYS = 16,
    parameter STAT_W = 8
) (
    input wire ref_clk,
    input wire reset_n,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Storage requests, one per channel, and grants
    input wire [7:0] store_req,
    output reg [7:0] store_grant,
    // Interrupt requests per level 1..8 (bit 0 = level 1)
    input wire [7:0] int_req,
    output reg [7:0] int_grant,
    output reg [3:0] int_level,
    // Multiplexer subchannel status presentation, standard and non-stacking
    input wire [N_SUBSYS-1:0] sub_present,
    input wire [8*N_SUBSYS-1:0] sub_addr,
    input wire [STAT_W*N_SUBSYS-1:0] sub_status,
    output reg [N_SUBSYS-1:0] sub_accept,
    output reg status_hold_off,
    output reg mux_std_int_req,
    // Program-flagged interrupt seen in a command word
    input wire pci_seen,
    input wire [7:0] pci_addr,
    // Status table subchannel write to main storage
    output reg tbl_wr,
    output reg [7:0] tbl_addr,
    output reg [STAT_W-1:0] tbl_status,
    output reg mux_tbl_int_req
);

// ----------------------------------------
// Address decoding
// ----------------------------------------
// Address class comes only from the address bits and the configuration
function is_standard;
    input [7:0] a;
    begin
        is_standard = a[7];
    end
endfunction

function is_comm;
    input [7:0] a;
    input wide;
    begin
        if (wide)
            is_comm = ~a[7] && (a[5:0] < `IOCPM_MAX_COMM_SUB);
        else
            is_comm = (a[7:5] == 3'h0) &&
                ({1'b0, a[4:0]} < `IOCPM_MAX_COMM_SUB);
    end
endfunction

// ----------------------------------------
// Storage priority, one-cycle grant
// ----------------------------------------
reg [7:0] next_store_grant;
always @* begin
    next_store_grant = 8'h00;
    // Later tests win, so lowest priority first
    if (store_req[0]) next_store_grant = 8'h01;
    if (store_req[7]) next_store_grant = 8'h80;
    if (store_req[4]) next_store_grant = 8'h10;
    if (store_req[3]) next_store_grant = 8'h08;
    if (store_req[5]) next_store_grant = 8'h20;
    if (store_req[2]) next_store_grant = 8'h04;
    if (store_req[1]) next_store_grant = 8'h02;
    if (store_req[6]) next_store_grant = 8'h40;
    // A holder releases for a cycle after its storage cycle
    if (store_grant != 8'h00) next_store_grant = 8'h00;
end

always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
        store_grant <= 8'h00;
    else
        store_grant <= next_store_grant;
end

// ----------------------------------------
// Interrupt priority (levels 1..8, level 0 unused)
// ----------------------------------------
reg [7:0] next_int_grant;
reg [3:0] next_int_level;
integer k;
always @* begin
    next_int_grant = 8'h00;
    next_int_level = `IOCPM_LEVEL_NONE;
    for (k = 7; k >= 0; k = k - 1) begin
        if (int_req[k]) begin
            next_int_grant = 8'h01 << k;
            next_int_level = k[3:0] + 4'h1;
        end
    end
end

always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        int_grant <= 8'h00;
        int_level <= `IOCPM_LEVEL_NONE;
    end else begin
        int_grant <= next_int_grant;
        int_level <= next_int_level;
    end
end

// ----------------------------------------
// Register bus
// ----------------------------------------
reg ctl_wide;
reg clear_pulse;
wire wb_req;
assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

// ----------------------------------------
// Standard-subchannel status acceptance
// ----------------------------------------
localparam ST_IDLE = 1'b0;
localparam ST_PEND = 1'b1;
reg state;
reg pend_pci;
reg [7:0] std_addr;
reg [STAT_W-1:0] std_status;
reg [N_SUBSYS-1:0] std_pick;
reg [N_SUBSYS-1:0] comm_pick;
wire [N_SUBSYS-1:0] cls_std;
wire [N_SUBSYS-1:0] cls_comm;
integer i;
integer j;

genvar g;
generate
    for (g = 0; g < N_SUBSYS; g = g + 1) begin : g_cls
        assign cls_std[g] = sub_present[g] &&
            is_standard(sub_addr[8*g +: 8]);
        assign cls_comm[g] = sub_present[g] &&
            is_comm(sub_addr[8*g +: 8], ctl_wide);
    end
endgenerate

// Lowest index is the highest-priority presenter
always @* begin
    std_pick = {N_SUBSYS{1'b0}};
    comm_pick = {N_SUBSYS{1'b0}};
    for (i = N_SUBSYS - 1; i >= 0; i = i - 1) begin
        if (cls_std[i]) begin
            std_pick = {N_SUBSYS{1'b0}};
            std_pick[i] = 1'b1;
        end
        if (cls_comm[i]) begin
            comm_pick = {N_SUBSYS{1'b0}};
            comm_pick[i] = 1'b1;
        end
    end
end

reg [7:0] pick_addr;
reg [STAT_W-1:0] pick_status;
reg [7:0] cpick_addr;
reg [STAT_W-1:0] cpick_status;
always @* begin
    pick_addr = 8'h00;
    pick_status = {STAT_W{1'b0}};
    cpick_addr = 8'h00;
    cpick_status = {STAT_W{1'b0}};
    for (j = 0; j < N_SUBSYS; j = j + 1) begin
        if (std_pick[j]) begin
            pick_addr = sub_addr[8*j +: 8];
            pick_status = sub_status[STAT_W*j +: STAT_W];
        end
        if (comm_pick[j]) begin
            cpick_addr = sub_addr[8*j +: 8];
            cpick_status = sub_status[STAT_W*j +: STAT_W];
        end
    end
end

wire pci_std;
assign pci_std = pci_seen && is_standard(pci_addr);

always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        state <= ST_IDLE;
        pend_pci <= 1'b0;
        std_addr <= 8'h00;
        std_status <= {STAT_W{1'b0}};
        status_hold_off <= 1'b0;
        mux_std_int_req <= 1'b0;
        sub_accept <= {N_SUBSYS{1'b0}};
    end else begin
        sub_accept <= {N_SUBSYS{1'b0}};
        case (state)
            ST_IDLE: begin
                // Only one standard presenter taken; others stack
                if (std_pick != {N_SUBSYS{1'b0}}) begin
                    sub_accept <= std_pick;
                    std_addr <= pick_addr;
                    std_status <= pick_status;
                    pend_pci <= 1'b0;
                    state <= ST_PEND;
                    status_hold_off <= 1'b1;
                    mux_std_int_req <= 1'b1;
                end else if (pci_std) begin
                    std_addr <= pci_addr;
                    pend_pci <= 1'b1;
                    state <= ST_PEND;
                    status_hold_off <= 1'b1;
                    mux_std_int_req <= 1'b1;
                end
            end
            ST_PEND: begin
                // Standard presenters are refused while pending
                if (clear_pulse) begin
                    state <= ST_IDLE;
                    status_hold_off <= 1'b0;
                    mux_std_int_req <= 1'b0;
                end
            end
            default: begin
                state <= ST_IDLE;
                status_hold_off <= 1'b0;
                mux_std_int_req <= 1'b0;
            end
        endcase
        // The top non-stacking presenter is relieved each cycle, interleaved
        // with standard service
        sub_accept <= (state == ST_IDLE ? std_pick :
            {N_SUBSYS{1'b0}}) | comm_pick;
    end
end

// ----------------------------------------
// Status table subchannel
// ----------------------------------------
// One comms write per cycle; extra presenters wait for a later cycle
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        tbl_wr <= 1'b0;
        tbl_addr <= 8'h00;
        tbl_status <= {STAT_W{1'b0}};
        mux_tbl_int_req <= 1'b0;
    end else begin
        tbl_wr <= comm_pick != {N_SUBSYS{1'b0}};
        if (comm_pick != {N_SUBSYS{1'b0}}) begin
            tbl_addr <= cpick_addr;
            tbl_status <= cpick_status;
        end
        // Set wins over the software clear
        if (comm_pick != {N_SUBSYS{1'b0}})
            mux_tbl_int_req <= 1'b1;
        else if (wb_req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == `IOCPM_REG_TABLE && wb_dat_i[0])
            mux_tbl_int_req <= 1'b0;
    end
end

// ----------------------------------------
// Wishbone slave, ack one cycle after request
// ----------------------------------------
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        ctl_wide <= 1'b0;
        clear_pulse <= 1'b0;
    end else begin
        wb_ack_o <= wb_req;
        clear_pulse <= 1'b0;
        if (wb_req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == `IOCPM_REG_CTRL) begin
            ctl_wide <= wb_dat_i[`IOCPM_CTRL_WIDE];
            clear_pulse <= wb_dat_i[`IOCPM_CTRL_CLEAR];
        end
        wb_dat_o <= 32'h00000000;
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `IOCPM_REG_CTRL:
                    wb_dat_o <= {30'h0, ctl_wide, 1'b0};
                `IOCPM_REG_STATUS:
                    wb_dat_o <= {28'h0, mux_tbl_int_req, pend_pci,
                        status_hold_off, state};
                `IOCPM_REG_STD_STAT:
                    wb_dat_o <= {{(24-STAT_W){1'b0}}, std_status, std_addr};
                `IOCPM_REG_TABLE:
                    wb_dat_o <= {{(24-STAT_W){1'b0}}, tbl_status, tbl_addr};
                `IOCPM_REG_GRANT:
                    wb_dat_o <= {20'h0, int_level, store_grant};
                default:
                    wb_dat_o <= 32'h00000000;
            endcase
        end
    end
end

endmodule // iocpm_top

// ===== bench/iocpm_chk.sv
// Checker for arbitration and status acceptance at the block's ports
`timescale 1ns/1ps
module iocpm_chk #(
    parameter N_SUBSYS = 16
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [7:0] store_req,
    input wire [7:0] store_grant,
    input wire [7:0] int_req,
    input wire [7:0] int_grant,
    input wire [3:0] int_level,
    input wire [8*N_SUBSYS-1:0] sub_addr,
    input wire [N_SUBSYS-1:0] sub_accept,
    input wire status_hold_off,
    input wire mux_std_int_req,
    input wire tbl_wr
);
    reg [N_SUBSYS-1:0] std_q;
    integer k;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    function [7:0] st_win(input [7:0] r);
        st_win = r[6] ? 8'h40 : r[1] ? 8'h02 : r[2] ? 8'h04 :
            r[5] ? 8'h20 : r[3] ? 8'h08 : r[4] ? 8'h10 :
            r[7] ? 8'h80 : {7'h00, r[0]};
    endfunction
    function automatic [3:0] lvl(input [7:0] r);
        integer j;
        lvl = 4'h0;
        for (j = 7; j >= 0; j = j - 1) begin
            if (r[j]) lvl = j[3:0] + 4'h1;
        end
    endfunction
    // Class of each presenter as seen on the edge that accepted it
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) std_q <= {N_SUBSYS{1'b0}};
        else for (k = 0; k < N_SUBSYS; k = k + 1) std_q[k] <= sub_addr[8*k+7];
    end
    a_store_onehot:
        assert property ($onehot0(store_grant)) else $error("grant not one-hot");
    a_store_single:
        assert property (|store_grant |=> store_grant == 8'h00)
        else $error("storage grant held too long");
    a_store_prio:
        assert property (|store_grant |-> store_grant == st_win($past(store_req)))
        else $error("storage grant not to top requester");
    a_store_serve:
        assert property (store_grant == 8'h00 && |store_req |=> |store_grant)
        else $error("pending storage request not served");
    a_int_level:
        assert property (int_level == lvl($past(int_req)))
        else $error("interrupt level wrong");
    a_int_grant:
        assert property (int_grant == ($past(int_req) & (~$past(int_req) + 8'h01)))
        else $error("interrupt grant wrong");
    a_hold_req:
        assert property (status_hold_off == mux_std_int_req)
        else $error("hold-off and request differ");
    a_std_refused:
        assert property ($past(status_hold_off) && status_hold_off
            |-> (sub_accept & std_q) == {N_SUBSYS{1'b0}})
        else $error("standard status taken while pending");
    a_std_single:
        assert property ($onehot0(sub_accept & std_q))
        else $error("two standard accepts at once");
    a_std_pend:
        assert property (|(sub_accept & std_q) |-> ##[0:1] status_hold_off)
        else $error("accept without pending");
    a_comm_table:
        assert property (|(sub_accept & ~std_q) |-> ##[0:1] tbl_wr)
        else $error("comms status not written to table");
    c_store: cover property (|store_grant);
    c_pend: cover property (|(sub_accept & std_q) ##1 status_hold_off);
    c_table: cover property (tbl_wr && status_hold_off);
endmodule // iocpm_chk

bind iocpm_top iocpm_chk #(.N_SUBSYS(N_SUBSYS)) chk_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .store_req(store_req),
    .store_grant(store_grant), .int_req(int_req), .int_grant(int_grant),
    .int_level(int_level), .sub_addr(sub_addr), .sub_accept(sub_accept),
    .status_hold_off(status_hold_off), .mux_std_int_req(mux_std_int_req),
    .tbl_wr(tbl_wr)
);

// ===== bench/iocpm_subsys_model.sv
// Peripheral subsystems presenting device status to the channel
`timescale 1ns/1ps
module iocpm_subsys_model #(
    parameter N = 4
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [N-1:0] post,
    input wire [8*N-1:0] addr_cfg,
    input wire [8*N-1:0] stat_cfg,
    input wire status_hold_off,
    input wire [N-1:0] sub_accept,
    output wire [N-1:0] sub_present,
    output wire [8*N-1:0] sub_addr,
    output reg [8*N-1:0] sub_status,
    output reg [N-1:0] stacked
);
    reg [N-1:0] stdm;
    integer k;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) stacked <= {N{1'b0}};
        else stacked <= (stacked | post) & ~sub_accept;
    end
    // Refused status stays stacked and is offered again unless held off
    assign sub_present = stacked & ~sub_accept &
        ~(stdm & {N{status_hold_off}});
    // Each subsystem keeps its own subchannel prefix for the whole operation
    assign sub_addr = addr_cfg;
    // Idle status lines show the inverse so stale data cannot match
    always @* begin
        for (k = 0; k < N; k = k + 1) begin
            stdm[k] = addr_cfg[8*k+7];
            sub_status[8*k+:8] = sub_present[k] ? stat_cfg[8*k+:8]
                : ~stat_cfg[8*k+:8];
        end
    end
endmodule // iocpm_subsys_model

// ===== bench/io_channel_priority_mux_status_tb.sv
// Bench for storage/interrupt priority and multiplexer status acceptance
`timescale 1ns/1ps
`include "iocpm_regs.vh"
module io_channel_priority_mux_status_tb;
    // Well under 15 subsystems use standard subchannels
    localparam N = 4;
    localparam [23:0] ORD = {3'h6, 3'h1, 3'h2, 3'h5, 3'h3, 3'h4, 3'h7, 3'h0};
    reg ref_clk, reset_n, cyc, stb, we, pci_seen;
    reg [7:0] adr, store_req, int_req, pci_addr, req, g;
    reg [31:0] wdat, d;
    reg [N-1:0] post;
    reg [8*N-1:0] addr_cfg, stat_cfg;
    wire [31:0] rdat;
    wire ack, status_hold_off, mux_std_int_req, mux_tbl_int_req;
    wire [7:0] store_grant, int_grant, tbl_addr, tbl_status;
    wire [3:0] int_level;
    wire [N-1:0] sub_present, sub_accept, stacked;
    wire [8*N-1:0] sub_addr, sub_status;
    integer mismatches, comparisons, cycles, i;
    iocpm_top #(.N_SUBSYS(N), .STAT_W(8)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .store_req(store_req),
        .store_grant(store_grant), .int_req(int_req), .int_grant(int_grant),
        .int_level(int_level), .sub_present(sub_present),
        .sub_addr(sub_addr), .sub_status(sub_status),
        .sub_accept(sub_accept), .status_hold_off(status_hold_off),
        .mux_std_int_req(mux_std_int_req), .pci_seen(pci_seen),
        .pci_addr(pci_addr), .tbl_wr(), .tbl_addr(tbl_addr),
        .tbl_status(tbl_status), .mux_tbl_int_req(mux_tbl_int_req)
    );
    iocpm_subsys_model #(.N(N)) sub_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .post(post),
        .addr_cfg(addr_cfg), .stat_cfg(stat_cfg),
        .status_hold_off(status_hold_off), .sub_accept(sub_accept),
        .sub_present(sub_present), .sub_addr(sub_addr),
        .sub_status(sub_status), .stacked(stacked)
    );
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] v);
        begin
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= v;
            @(posedge ref_clk);
            while (ack !== 1'b1) @(posedge ref_clk);
            d = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            wb(1'b0, a, 32'h0);
            chk("register", d, exp);
        end
    endtask
    function sig(input [1:0] w);
        case (w)
            2'h0: sig = status_hold_off;
            2'h1: sig = |store_grant;
            default: sig = |stacked;
        endcase
    endfunction
    task wait_on(input [1:0] w, input v);
        integer n;
        begin
            n = 0;
            while (sig(w) !== v && n < 200) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            chk("wait", {31'h0, sig(w)}, {31'h0, v});
        end
    endtask
    task pulse(input [N-1:0] p);
        begin
            post <= p;
            @(posedge ref_clk);
            post <= {N{1'b0}};
        end
    endtask
    task print_verdict;
        begin
            if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            print_verdict;
        end
    end
    initial begin
        {mismatches, comparisons, cycles} = 96'h0;
        {reset_n, cyc, stb, we, pci_seen, adr, wdat} = 'h0;
        {store_req, int_req, pci_addr, post} = 'h0;
        addr_cfg = 32'h1C05_958D;
        stat_cfg = 32'h4433_2211;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (i = 0; i < 6; i = i + 1) rd(i * 4, 32'h0);
        req = 8'hFF;
        store_req <= req;
        for (i = 0; i < 8; i = i + 1) begin
            wait_on(2'h1, 1'b1);
            g = store_grant;
            chk("grant", {24'h0, g}, 32'h1 << ORD[23-3*i-:3]);
            req = req & ~g;
            store_req <= req;
            @(posedge ref_clk);
        end
        for (i = 1; i <= 8; i = i + 1) begin
            int_req <= 8'hFF << (i - 1);
            repeat (2) @(posedge ref_clk);
            chk("level", {28'h0, int_level}, i);
            chk("igrant", {24'h0, int_grant}, 32'h1 << (i - 1));
        end
        rd(`IOCPM_REG_GRANT, 32'h800);
        int_req <= 8'h00;
        pulse(4'h3);
        wait_on(2'h0, 1'b1);
        chk("std_int", {31'h0, mux_std_int_req}, 32'h1);
        rd(`IOCPM_REG_STD_STAT, 32'h118D);
        chk("stacked", {28'h0, stacked}, 32'h2);
        rd(`IOCPM_REG_STATUS, 32'h3);
        wb(1'b1, `IOCPM_REG_CTRL, 32'h1);
        wait_on(2'h0, 1'b0);
        wait_on(2'h0, 1'b1);
        rd(`IOCPM_REG_STD_STAT, 32'h2295);
        pulse(4'hC);
        // Let the posted status reach the model before waiting for relief
        wait_on(2'h2, 1'b1);
        wait_on(2'h2, 1'b0);
        rd(`IOCPM_REG_TABLE, 32'h441C);
        chk("tbl_addr", {24'h0, tbl_addr}, 32'h1C);
        chk("tbl_status", {24'h0, tbl_status}, 32'h44);
        chk("tbl_int", {31'h0, mux_tbl_int_req}, 32'h1);
        rd(`IOCPM_REG_STATUS, 32'hB);
        addr_cfg[31:24] <= 8'h1D;
        pulse(4'h8);
        repeat (10) @(posedge ref_clk);
        chk("stacked", {28'h0, stacked}, 32'h8);
        addr_cfg[31:24] <= 8'h5C;
        wb(1'b1, `IOCPM_REG_CTRL, 32'h2);
        wait_on(2'h2, 1'b0);
        rd(`IOCPM_REG_TABLE, 32'h445C);
        wb(1'b1, `IOCPM_REG_CTRL, 32'h3);
        wait_on(2'h0, 1'b0);
        wb(1'b1, `IOCPM_REG_TABLE, 32'h1);
        rd(`IOCPM_REG_STATUS, 32'h0);
        pci_addr <= 8'h90;
        pci_seen <= 1'b1;
        @(posedge ref_clk);
        pci_seen <= 1'b0;
        wait_on(2'h0, 1'b1);
        rd(`IOCPM_REG_STATUS, 32'h7);
        print_verdict;
    end
endmodule // io_channel_priority_mux_status_tb
